//--- design/acs_pkg.sv
package acs_pkg;
  // ---------------------------------------------------------------------------
  // Frame layout.
  // ---------------------------------------------------------------------------
  localparam int FRAME_BITS    = 16;       // Serial clocks in one frame.
  localparam int BIT_WRITE     = 15;       // Write bit position.
  localparam int BIT_ZERO      = 14;       // Zero bit position.
  localparam int BIT_REGSEL    = 13;       // Register select position.
  localparam int BIT_CHAN      = 10;       // Channel address position.
  localparam int BIT_INCFG_HI  = 9;        // Input configuration high bit.
  localparam int BIT_PM_HI     = 7;        // Power mode high bit.
  localparam int BIT_CODING    = 5;        // Output coding bit.
  localparam int BIT_REF       = 4;        // Reference select bit.
  localparam int BIT_SEQ_HI    = 3;        // Sequencer control high bit.
  localparam int BIT_R0_HI     = 12;       // Channel 0 range code high bit.
  localparam int BIT_R1_HI     = 8;        // Channel 1 range code high bit.
  localparam int CTL_LOAD_RISE = 15;       // Control loads on this rising edge.
  localparam int RNG_LOAD_FALL = 11;       // Range loads on this falling edge.

  // ---------------------------------------------------------------------------
  // Codes and reset values.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] PM_NORMAL   = 2'h0;
  localparam logic [1:0] PM_STANDBY  = 2'h1;
  localparam logic [1:0] PM_AUTOSHDN = 2'h2;
  localparam logic [1:0] PM_FULLSHDN = 2'h3;
  localparam logic [1:0] CFG_SINGLE  = 2'h0;
  localparam logic [1:0] CFG_PSEUDO  = 2'h1;
  localparam logic [1:0] CFG_DIFF    = 2'h2;
  localparam logic [1:0] CFG_ILLEGAL = 2'h3;
  localparam logic [1:0] SEQ_ON      = 2'h2;
  localparam logic [1:0] RANGE_10V   = 2'h0;
  localparam logic [1:0] RANGE_5V    = 2'h1;
  localparam logic [1:0] RANGE_2V5   = 2'h2;
  localparam logic [1:0] RANGE_UNI   = 2'h3;
  localparam logic [5:0] RANGE_RST   = 6'h00;
  localparam logic [11:0] CTL_RST    = 12'h000;

  // ---------------------------------------------------------------------------
  // Host register map.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] HOST_FRAME  = 4'h0;  // Write: send frame; read: last frame.
  localparam logic [3:0] HOST_STATUS = 4'h4;  // Read: bit 0 busy, bit 1 done.
  localparam logic [3:0] HOST_DIV    = 4'h8;  // Serial clock half period minus one, in core cycles.
  localparam logic [7:0] DIV_RST     = 8'h04;
  localparam int REF_WAIT_US = 500;           // Reference buffer settling time.
  localparam int CLK_MHZ     = 50;

  typedef enum logic [2:0] {
    ACS_IDLE  = 3'b001,
    ACS_SHIFT = 3'b010,
    ACS_GAP   = 3'b100
  } acs_hstate_t;

  // Builds a range-write frame from two channel codes.
  function automatic logic [15:0] acs_range_frame(input logic [1:0] c0, input logic [1:0] c1);
    acs_range_frame = {1'b1, 1'b0, 1'b1, c0, 2'h0, c1, 7'h00};
  endfunction
endpackage

//--- design/acs_link_if.sv
`timescale 1ns/1ps
// Serial link between controller and converter configuration logic.
interface acs_link_if;
  logic cs_n;   // Frame select, active low.
  logic sclk;   // Serial clock, made by the host.
  logic din;    // Serial data toward the device.
  modport host (output cs_n, output sclk, output din);
  modport dev  (input cs_n, input sclk, input din);
endinterface

//--- design/acs_dev.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// (R1) Mode 11: full shutdown, registers kept
// (R2) Mode 10: autoshutdown at 15th rising edge
// (R3) Mode 01: autostandby at 15th edge, reference on
// (R4) Mode 00: everything powered always
// (R5) Sequencer 0x or 11: convert addressed channel
// (R6) Sequencer 10: channel 0 up to address
// (R7) Sequenced channels use their latest range
// (R8) Host idles data or write zero
// (R9) Host clears sequencer bits to stop
// (R10) Range register: six bits, two codes
// (R11) Range written when write and select set
// (R12) Selected channel gets its stored range
// (R13) Range codes: 10V, 5V, 2.5V, unipolar
// (R14) Both ranges reset to plus/minus 10V
// (R15) Reference bit one selects internal reference
// (R16) Reference bit resets to external
// (R17) Host discards first internal-reference result
// (R18) Host waits 500 us after reference enable; the host only counts it down in status bit 3 and does not hold frames
// (R19) Decode write, zero, select; write zero ignored; the code does not check the zero bit
// (R20) Range captured on 11th falling edge
// (R21) Address picks next or final channel
// (R22) Input configurations 00, 01, 10; 11 illegal
// (R23) Range frame layout: code, 00, code, zeros
module acs_dev
  import acs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  acs_link_if.dev         link,
  output logic [11:0]     ctl_word,        // Stored control register.
  output logic [5:0]      range_word,      // Stored range register.
  output logic            conv_chan,       // Channel of the current conversion.
  output logic [1:0]      conv_range,      // Range code applied to it.
  output logic [2:0]      range_onehot_10, // One-hot decode: 10V, 5V, 2.5V.
  output logic            range_unipolar,  // Unipolar 0 to 10 V selected.
  output logic            in_pos_sel,      // Positive input: 0 or 1.
  output logic            in_neg_gnd,      // Negative input is analog ground.
  output logic            cfg_illegal,     // Input configuration 11 stored.
  output logic            ref_internal,    // Internal reference in use.
  output logic            ref_powered,     // Reference circuitry powered.
  output logic            core_powered,    // Converter core powered.
  output logic            coding_binary    // Straight binary output coding.
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------------
  logic [2:0] s1_r;   // First stage, read only by the second.
  logic [2:0] s2_r;   // Second stage: cs_n, sclk, din.
  logic       sclk_d_r; // Previous synchronised clock level.
  logic       cs_d_r;   // Previous synchronised select level.

  // Two flops per pin since the link is asynchronous to core_clk.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r     <= 3'h7;
      s2_r     <= 3'h7;
      sclk_d_r <= 1'b1;
      cs_d_r   <= 1'b1;
    end else begin
      s1_r     <= {link.cs_n, link.sclk, link.din};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[1];
      cs_d_r   <= s2_r[2];
    end
  end

  logic cs_n_s, din_s, rise, fall, cs_rise, cs_fall;
  assign cs_n_s  = s2_r[2];
  assign din_s   = s2_r[0];
  assign rise    = !cs_n_s && s2_r[1] && !sclk_d_r;
  assign fall    = !cs_n_s && !s2_r[1] && sclk_d_r;
  assign cs_rise = cs_n_s && !cs_d_r;
  assign cs_fall = !cs_n_s && cs_d_r;

  // ---------------------------------------------------------------------------
  // Frame shifter.
  // ---------------------------------------------------------------------------
  logic [15:0] shift_r;   // Bits taken so far, newest in bit 0.
  logic [4:0]  nfall_r;   // Falling edges counted in this frame.
  logic [4:0]  nrise_r;   // Rising edges counted in this frame.

  // Data is taken on the falling serial clock edge; counts restart per frame.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 16'h0000;
      nfall_r <= 5'h00;
      nrise_r <= 5'h00;
    end else if (cs_fall) begin
      shift_r <= 16'h0000;
      nfall_r <= 5'h00;
      nrise_r <= 5'h00;
    end else begin
      if (fall && nfall_r < 5'(FRAME_BITS)) begin
        shift_r <= {shift_r[14:0], din_s};
        nfall_r <= nfall_r + 5'h01;
      end
      if (rise && nrise_r < 5'(FRAME_BITS)) begin
        nrise_r <= nrise_r + 5'h01;
      end
    end
  end

  // Header bits sit at the top of the cnt bits taken so far; pos picks the frame bit.
  function automatic logic hdr_bit(input logic [15:0] sh, input int cnt, input int pos);
    hdr_bit = sh[cnt - 1 - (FRAME_BITS - 1 - pos)];
  endfunction

  // ---------------------------------------------------------------------------
  // Register loads.
  // ---------------------------------------------------------------------------
  logic rng_load, ctl_load;
  // Range: the 11th falling edge takes in bit 5; write and select must be 1.
  assign rng_load = fall && (nfall_r == 5'(RNG_LOAD_FALL - 1))
                    && hdr_bit({shift_r[14:0], din_s}, RNG_LOAD_FALL, BIT_WRITE)
                    && hdr_bit({shift_r[14:0], din_s}, RNG_LOAD_FALL, BIT_REGSEL); // [R11] [R19] [R20]
  // Control: loaded on the 15th rising edge with write 1 and select 0; fifteen bits are in.
  assign ctl_load = rise && (nrise_r == 5'(CTL_LOAD_RISE - 1))
                    && (nfall_r == 5'(CTL_LOAD_RISE))
                    && hdr_bit(shift_r, CTL_LOAD_RISE, BIT_WRITE)
                    && !hdr_bit(shift_r, CTL_LOAD_RISE, BIT_REGSEL); // [R19]

  logic [5:0]  range_r;   // Write-only range register, {ch0 code, 00, ch1 code}.
  logic [11:0] ctl_r;     // Control bits 11..0 of the frame.

  // Range codes default to plus/minus 10 V until written.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      range_r <= RANGE_RST; // [R14]
    end else if (rng_load) begin
      // Ten bits sit in the shifter here; the codes are frame bits 12 down to 7.
      range_r <= shift_r[6:1]; // [R10] [R23]
    end
  end

  // Control contents survive every power mode; only a write changes them.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r <= CTL_RST; // [R16]
    end else if (ctl_load) begin
      // Frame bit 0 has not arrived yet; it is always zero, so it is stored as zero.
      ctl_r <= {shift_r[10:0], 1'b0}; // [R1]
    end
  end

  // ---------------------------------------------------------------------------
  // Power modes.
  // ---------------------------------------------------------------------------
  logic [1:0] pm;
  logic       asleep_r;   // Automatic mode asleep after the 15th rising edge.
  assign pm = ctl_r[BIT_PM_HI -: 2];

  // Auto modes sleep from the 15th rising edge and wake at the frame's end.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      asleep_r <= 1'b0;
    end else if (cs_rise) begin
      asleep_r <= 1'b0;
    end else if (rise && nrise_r == 5'(CTL_LOAD_RISE - 1)) begin
      asleep_r <= 1'b1; // [R2] [R3]
    end
  end

  // Power state follows the stored mode; auto modes also follow the sleep flag.
  always_comb begin
    case (pm)
      PM_FULLSHDN: begin
        core_powered = 1'b0; // [R1]
        ref_powered  = 1'b0;
      end
      PM_AUTOSHDN: begin
        core_powered = !asleep_r; // [R2]
        ref_powered  = !asleep_r;
      end
      PM_STANDBY: begin
        core_powered = !asleep_r; // [R3]
        ref_powered  = 1'b1;
      end
      default: begin
        core_powered = 1'b1; // [R4]
        ref_powered  = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Channel sequencer.
  // ---------------------------------------------------------------------------
  logic seq_on, chan_r;
  logic seq_run_r;   // Sequencer was already on at the previous frame start.
  assign seq_on = (ctl_r[BIT_SEQ_HI -: 2] == SEQ_ON);

  // Sequence starts at channel 0, steps to the address bit, then wraps.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_r    <= 1'b0;
      seq_run_r <= 1'b0;
    end else if (cs_fall) begin
      seq_run_r <= seq_on;
      if (!seq_on) begin
        chan_r <= ctl_r[BIT_CHAN]; // [R5] [R21]
      end else if (!seq_run_r || chan_r == ctl_r[BIT_CHAN] || !core_powered) begin
        chan_r <= 1'b0; // [R6]
      end else begin
        chan_r <= chan_r + 1'b1; // [R6] [R21]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  logic [1:0] cfg;
  assign cfg = ctl_r[BIT_INCFG_HI -: 2];

  // Stored range follows the channel in use, sequenced or not.
  assign conv_range     = conv_chan ? range_word[1:0] : range_word[5:4]; // [R7] [R12]
  assign range_onehot_10 = {conv_range == RANGE_2V5, conv_range == RANGE_5V,
                            conv_range == RANGE_10V}; // [R13]
  assign range_unipolar = (conv_range == RANGE_UNI); // [R13]
  assign cfg_illegal    = (cfg == CFG_ILLEGAL); // [R22]
  assign in_neg_gnd     = (cfg == CFG_SINGLE); // [R22]
  assign in_pos_sel     = (cfg == CFG_SINGLE) ? conv_chan : 1'b0; // [R22]
  assign ref_internal   = ctl_r[BIT_REF]; // [R15]
  assign coding_binary  = ctl_r[BIT_CODING];
  assign ctl_word       = ctl_r;
  assign range_word     = range_r;
  assign conv_chan      = chan_r;
endmodule

//--- design/acs_host.sv
`timescale 1ns/1ps
// Controller end: software writes a 16-bit frame, the host shifts it out.
module acs_host
  import acs_pkg::*;
#(
  parameter int REF_WAIT_CYC = REF_WAIT_US * CLK_MHZ   // Reference settling count.
)
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [15:0]      rdata,
  acs_link_if.host         link
);
  // ---------------------------------------------------------------------------
  // Registers and shifter.
  // ---------------------------------------------------------------------------
  acs_hstate_t st_r;
  logic [15:0] frame_r;   // Frame being sent, MSB first.
  logic [15:0] last_r;    // Last frame sent.
  logic [7:0]  div_r;     // Serial clock half period minus one, in core cycles.
  logic [7:0]  cnt_r;     // Half period counter.
  logic [4:0]  bit_r;     // Bits left to send.
  logic        sclk_r;
  logic        done_r;    // Sticky frame done.
  logic        ref_seen_r; // Internal reference already enabled once.
  logic        discard_r; // Result of the last frame must be discarded.
  logic [31:0] refw_r;    // Reference settling countdown.

  logic start;
  assign start = wr_en && addr == HOST_FRAME && st_r == ACS_IDLE;

  // Serial clock idles high; data changes on rising edges, device takes on falling.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= ACS_IDLE;
      frame_r <= 16'h0000;
      cnt_r   <= 8'h00;
      bit_r   <= 5'h00;
      sclk_r  <= 1'b1;
    end else begin
      case (st_r)
        ACS_IDLE: begin
          sclk_r <= 1'b1;
          if (start) begin
            frame_r <= wdata;
            bit_r   <= 5'(FRAME_BITS);
            cnt_r   <= div_r;
            st_r    <= ACS_SHIFT;
          end
        end
        ACS_SHIFT: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            cnt_r  <= div_r;
            sclk_r <= !sclk_r;
            if (!sclk_r) begin
              frame_r <= {frame_r[14:0], 1'b0};
              bit_r   <= bit_r - 5'h01;
              if (bit_r == 5'h01) begin
                st_r <= ACS_GAP;
              end
            end
          end
        end
        ACS_GAP: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            st_r <= ACS_IDLE;
          end
        end
        default: st_r <= ACS_IDLE;
      endcase
    end
  end

  // Done, last frame and reference bookkeeping; a new done wins over a read clear.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r     <= 1'b0;
      last_r     <= 16'h0000;
      ref_seen_r <= 1'b0;
      discard_r  <= 1'b0;
      refw_r     <= 32'h0;
    end else begin
      if (st_r == ACS_GAP && cnt_r == 8'h00) begin
        done_r <= 1'b1;
      end else if (rd_en && addr == HOST_STATUS) begin
        done_r <= 1'b0;
      end
      if (start) begin
        last_r <= wdata;
        discard_r <= 1'b0;
        if (wdata[BIT_WRITE] && !wdata[BIT_REGSEL] && wdata[BIT_REF] && !ref_seen_r) begin
          ref_seen_r <= 1'b1;
          discard_r  <= 1'b1;  // [R17]
          refw_r     <= 32'(REF_WAIT_CYC); // [R18]
        end
      end else if (refw_r != 32'h0) begin
        refw_r <= refw_r - 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= DIV_RST;
    end else if (wr_en && addr == HOST_DIV) begin
      div_r <= wdata[7:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        HOST_FRAME:  rdata <= last_r;
        HOST_STATUS: rdata <= {12'h000, refw_r != 32'h0, discard_r, done_r, st_r != ACS_IDLE};
        HOST_DIV:    rdata <= {8'h00, div_r};
        default:     rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Frames the software writes decide R8, R9, R11 and R23 content; idle data is low.
  assign link.cs_n = (st_r == ACS_IDLE);
  assign link.sclk = sclk_r;
  assign link.din  = (st_r == ACS_SHIFT) ? frame_r[FRAME_BITS - 1] : 1'b0; // [R8]
endmodule

//--- sim/acs_link_assertions.sv
`timescale 1ns/1ps
// Watches the serial link and the device's decoded outputs.
module acs_link_assertions
  import acs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        din,
  input wire logic [11:0] ctl_word,
  input wire logic [5:0]  range_word,
  input wire logic        conv_chan,
  input wire logic [1:0]  conv_range,
  input wire logic [2:0]  range_onehot_10,
  input wire logic        range_unipolar,
  input wire logic        in_pos_sel,
  input wire logic        in_neg_gnd,
  input wire logic        cfg_illegal,
  input wire logic        ref_internal,
  input wire logic        ref_powered,
  input wire logic        core_powered
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------------------
  // Helper logic.
  // ---------------------------------------------------------------------------
  logic [4:0] fall_cnt_r;  // Serial clock falls seen in the current frame.

  // Counts falls while selected; a short frame would leave it below sixteen.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_cnt_r <= 5'h00;
    end else if (cs_n) begin
      fall_cnt_r <= 5'h00;
    end else if ($fell(sclk)) begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  frame_length_a: assert property ($rose(cs_n) |-> fall_cnt_r == 5'h10)
    else $error("frame did not carry sixteen clocks");
  idle_clock_a: assert property (cs_n |-> sclk)
    else $error("serial clock low outside a frame");
  idle_data_a: assert property (cs_n [*3] |-> !din)
    else $error("data line not low while idle");
  range_hold_a: assert property (!$stable(range_word) |-> !cs_n)
    else $error("range changed outside a frame");
  ctl_hold_a: assert property (!$stable(ctl_word) |-> !cs_n)
    else $error("control changed outside a frame");
  ref_select_a: assert property (ref_internal == ctl_word[4])
    else $error("reference select does not follow control");
  full_shutdown_a: assert property (ctl_word[7:6] == PM_FULLSHDN |->
    !core_powered && !ref_powered)
    else $error("powered in full shutdown");
  normal_power_a: assert property (cs_n [*4] ##0 ctl_word[7:6] == PM_NORMAL |->
    core_powered && ref_powered)
    else $error("not powered in normal mode");
  standby_ref_a: assert property (ctl_word[7:6] == PM_STANDBY |-> ref_powered)
    else $error("reference off in standby");
  auto_sleep_a: assert property ($rose(cs_n) && ctl_word[7:6] == PM_AUTOSHDN |->
    !$past(core_powered))
    else $error("core awake at frame end in autoshutdown");
  range_route_a: assert property (conv_range ==
    (conv_chan ? range_word[1:0] : range_word[5:4]))
    else $error("applied range is not the channel's code");
  range_decode_a: assert property (range_unipolar == (conv_range == RANGE_UNI) &&
    range_onehot_10 == (conv_range == RANGE_UNI ? 3'h0 : 3'h1 << conv_range))
    else $error("range decode wrong");
  cfg_flag_a: assert property (cfg_illegal == (ctl_word[9:8] == CFG_ILLEGAL))
    else $error("illegal configuration flag wrong");
  input_route_a: assert property (ctl_word[9:8] != CFG_ILLEGAL |->
    (ctl_word[9:8] == CFG_SINGLE ? in_neg_gnd && in_pos_sel == conv_chan
                                 : !in_neg_gnd && !in_pos_sel))
    else $error("input routing wrong");
endmodule

//--- sim/adc_config_sequencer_tb.sv
`timescale 1ns/1ps
// Host and device joined over the link; software frames go in at the host.
module adc_config_sequencer_tb
  import acs_pkg::*;
;
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [15:0] wdata     = 16'h0000;
  logic        wr_en     = 1'b0;
  logic        rd_en     = 1'b0;
  logic [15:0] rdata;
  logic [11:0] ctl_word;
  logic [5:0]  range_word;
  logic        conv_chan;
  logic [1:0]  conv_range;
  logic [2:0]  range_onehot_10;
  logic        range_unipolar;
  logic        in_pos_sel;
  logic        in_neg_gnd;
  logic        cfg_illegal;
  logic        ref_internal;
  logic        ref_powered;
  logic        core_powered;
  logic        coding_binary;
  logic        asleep_r  = 1'b0;  // Core seen off during the last frame.
  logic        ref_off_r = 1'b0;  // Reference seen off during the last frame.
  logic        cs_seen_r = 1'b1;  // Frame select one cycle ago.
  int          failures  = 0;
  int          cmp_count = 0;
  int          seed      = 39967;

  acs_link_if link ();
  // A short reference wait keeps the run brief; the count is not checked here.
  acs_host #(.REF_WAIT_CYC(20)) u_acs_host (.core_clk(core_clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .link(link.host));
  acs_dev u_acs_dev (.core_clk(core_clk), .arst_n(arst_n), .link(link.dev),
    .ctl_word(ctl_word), .range_word(range_word), .conv_chan(conv_chan),
    .conv_range(conv_range), .range_onehot_10(range_onehot_10),
    .range_unipolar(range_unipolar), .in_pos_sel(in_pos_sel), .in_neg_gnd(in_neg_gnd),
    .cfg_illegal(cfg_illegal), .ref_internal(ref_internal), .ref_powered(ref_powered),
    .core_powered(core_powered), .coding_binary(coding_binary));
  acs_link_assertions u_acs_link_assertions (.core_clk(core_clk), .arst_n(arst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din), .ctl_word(ctl_word),
    .range_word(range_word), .conv_chan(conv_chan), .conv_range(conv_range),
    .range_onehot_10(range_onehot_10), .range_unipolar(range_unipolar),
    .in_pos_sel(in_pos_sel), .in_neg_gnd(in_neg_gnd), .cfg_illegal(cfg_illegal),
    .ref_internal(ref_internal), .ref_powered(ref_powered), .core_powered(core_powered));

  // ---------------------------------------------------------------------------
  // Clock, power monitor and helpers.
  // ---------------------------------------------------------------------------
  always #10 core_clk = ~core_clk;

  // Sticky record of any sleep seen while a frame is open, restarted as each frame opens.
  always @(posedge core_clk) begin
    cs_seen_r <= link.cs_n;
    if (!link.cs_n) begin
      asleep_r  <= (asleep_r & ~cs_seen_r) | ~core_powered;
      ref_off_r <= (ref_off_r & ~cs_seen_r) | ~ref_powered;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Sends one frame and polls busy under a bound; a hang counts as a mismatch.
  task automatic send(input logic [15:0] f);
    logic [15:0] s;
    bus_wr(HOST_FRAME, f);
    for (int n = 0; n < 300; n++) begin
      bus_rd(HOST_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    chk({14'h0, s[1:0]}, 16'h0002);
    bus_rd(HOST_FRAME, s);
    chk(s, f);
  endtask

  function automatic logic [15:0] ctl_frame(input logic ch, input logic [1:0] cfg,
      input logic [1:0] pm, input logic cod, input logic rf, input logic [1:0] sq);
    return {3'b100, 2'b00, ch, cfg, pm, cod, rf, sq, 2'b00};
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------------------
  initial begin
    logic [15:0] f;
    logic [15:0] s;
    logic [1:0]  c0;
    logic [1:0]  c1;
    logic        ch;
    logic        rf_seen;
    rf_seen = 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({4'h0, ctl_word}, {4'h0, CTL_RST});
    chk({10'h0, range_word}, {10'h0, RANGE_RST});
    chk({15'h0, ref_internal}, 16'h0000);
    chk({15'h0, core_powered}, 16'h0001);
    bus_rd(4'hc, s);
    chk(s, 16'h0000);
    $display("reset test done");
    // Every code on each channel, then each channel 0 code with a random channel 1 code.
    for (int i = 0; i < 8; i++) begin
      c0 = i[1:0];
      c1 = i[2] ? 2'($random(seed)) : ~i[1:0];
      send({3'b101, c0, 2'b00, c1, 7'h00});
      chk({10'h0, range_word}, {10'h0, c0, 2'b00, c1});
      chk({14'h0, conv_range}, {14'h0, conv_chan ? c1 : c0});
    end
    $display("range test done");
    // Frames with the write bit clear must leave both registers alone.
    repeat (4) begin
      send({1'b0, 15'($random(seed))});
      chk({4'h0, ctl_word}, {4'h0, CTL_RST});
      chk({10'h0, range_word}, {10'h0, c0, 2'b00, c1});
    end
    $display("ignored frame test done");
    // Each mode is written twice; the second frame shows the settled behaviour.
    for (int p = 0; p < 4; p++) begin
      f = ctl_frame(1'b0, 2'(p), 2'(p), 1'($random(seed)), 1'($random(seed)), 2'h0);
      send(f);
      bus_rd(HOST_STATUS, s);
      chk({15'h0, s[2]}, {15'h0, f[4] & ~rf_seen});
      rf_seen = rf_seen | f[4];
      send(f);
      chk({4'h0, ctl_word}, {4'h0, f[11:0]});
      chk({14'h0, ref_internal, coding_binary}, {14'h0, f[4], f[5]});
      chk({14'h0, asleep_r, ref_off_r}, {14'h0, p != 0, p >= 2});
      chk({14'h0, cfg_illegal, core_powered}, {14'h0, p == 3, p != 3});
    end
    $display("power mode test done");
    bus_wr(HOST_DIV, 16'h0006);
    send(ctl_frame(1'b1, CFG_SINGLE, PM_NORMAL, 1'b0, 1'b0, SEQ_ON));
    send(16'h0000);
    chk({15'h0, conv_chan}, 16'h0000);
    ch = conv_chan;
    repeat (4) begin
      send(16'h0000);
      chk({15'h0, conv_chan}, {15'h0, ~ch});
      chk({14'h0, conv_range}, {14'h0, conv_chan ? c1 : c0});
      ch = conv_chan;
    end
    send(ctl_frame(1'b0, CFG_SINGLE, PM_NORMAL, 1'b0, 1'b0, SEQ_ON));
    repeat (2) begin
      send(16'h0000);
      chk({15'h0, conv_chan}, 16'h0000);
    end
    // Leaving the sequence, and non-sequencing codes 11 and 00.
    foreach (c0[k]) begin
      f = ctl_frame(~k[0], CFG_SINGLE, PM_NORMAL, 1'b0, 1'b0, {k[0], k[0]});
      send(f);
      send(16'h0000);
      send(16'h0000);
      chk({15'h0, conv_chan}, {15'h0, ~k[0]});
    end
    $display("sequencer test done");
    end_of_test();
  end

  // Cuts a hang short; the tests need about a seventh of this span.
  initial begin
    #1_000_000;
    failures++;
    end_of_test();
  end
endmodule
